// ==== include/bce_pkg.sv ====
/*
  Constants for the byte processor execution datapath: opcode groups,
  exact opcodes, machine cycle timing and reset values.
  Assumes a single clk_sys domain; no timescale needed here.
*/
package bce_pkg;
  // Opcode high nibbles that take a register nibble
  localparam logic [3:0] OPH_LOAD_N = 4'h0;
  localparam logic [3:0] OPH_INC_N = 4'h1;
  localparam logic [3:0] OPH_DEC_N = 4'h2;
  localparam logic [3:0] OPH_LOAD_ADV = 4'h4;
  localparam logic [3:0] OPH_STORE_N = 4'h5;
  localparam logic [3:0] OPH_GET_LO = 4'h8;
  localparam logic [3:0] OPH_GET_HI = 4'h9;
  localparam logic [3:0] OPH_PUT_LO = 4'hA;
  localparam logic [3:0] OPH_PUT_HI = 4'hB;
  // Exact opcodes
  localparam logic [7:0] OP_BUMP_X = 8'h60;
  localparam logic [7:0] OP_LDX_ADV = 8'h72;
  localparam logic [7:0] OP_STX_BACK = 8'h73;
  localparam logic [7:0] OP_ADD_C_M = 8'h74;
  localparam logic [7:0] OP_ROR_C = 8'h76;
  localparam logic [7:0] OP_SUB_B_M = 8'h77;
  localparam logic [7:0] OP_ADD_C_I = 8'h7C;
  localparam logic [7:0] OP_ROL_C = 8'h7E;
  localparam logic [7:0] OP_LDX = 8'hF0;
  localparam logic [7:0] OP_OR_M = 8'hF1;
  localparam logic [7:0] OP_AND_M = 8'hF2;
  localparam logic [7:0] OP_XOR_M = 8'hF3;
  localparam logic [7:0] OP_ADD_M = 8'hF4;
  localparam logic [7:0] OP_SHR = 8'hF6;
  localparam logic [7:0] OP_SUB_M = 8'hF7;
  localparam logic [7:0] OP_LD_I = 8'hF8;
  localparam logic [7:0] OP_OR_I = 8'hF9;
  localparam logic [7:0] OP_AND_I = 8'hFA;
  localparam logic [7:0] OP_XOR_I = 8'hFB;
  localparam logic [7:0] OP_ADD_I = 8'hFC;
  localparam logic [7:0] OP_SHL = 8'hFE;
  localparam logic [7:0] OP_SUB_I = 8'hFF;
  // Timing: eight clocks per machine cycle, two machine cycles per instruction
  localparam int CLK_PER_MCYC = 8;
  localparam int MCYC_PER_INSTR = 2;
  localparam int INSTR_CLKS = CLK_PER_MCYC * MCYC_PER_INSTR;
  localparam logic [3:0] LAST_TICK = 4'(INSTR_CLKS - 1);
  localparam logic [3:0] MEM_TICK = 4'(CLK_PER_MCYC + 3);
  localparam logic [3:0] REG_COUNT_M1 = 4'hF;
  // Reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [15:0] PTR_RST = 16'h0000;
  // Execution states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FETCH = 3'b010,
    ST_EXEC = 3'b100
  } bce_state_t;
endpackage : bce_pkg

// ==== src/bce_datapath.sv ====
/*
  Execution datapath of an 8-bit processor: accumulator, carry flag,
  sixteen 16-bit pointer registers, register/memory/logic/shift/arith ops.
  Assumes a sequencer hands in one opcode per start pulse and that the
  byte-wide memory answers a read within the same clock (synchronous
  data input registered at MEM_TICK).
*/
// What this block does
// - Bits of every register count up from bit zero, the least significant.
// - A pointer is chosen by opcode nibble, index selector or program-counter selector.
// - 1N increments, 2N decrements the nibble pointer; 60 increments the index pointer.
// - 8N copies pointer low byte, 9N pointer high byte, into the accumulator.
// - AN and BN write accumulator into pointer low or high byte, accumulator kept.
// - 0N with nonzero nibble loads accumulator from memory at nibble pointer.
// - F0 loads via index pointer; 4N and 72 load then advance their pointer.
// - F8 loads the following byte and advances the program counter past it.
// - 5N stores accumulator at nibble pointer address, nothing else changes.
// - 73 stores accumulator at index pointer, then decrements that pointer.
// - F1 ORs memory at index pointer into accumulator; F9 uses immediate byte.
// - F3 XORs memory at index pointer into accumulator; FB uses immediate byte.
// - F2 ANDs memory at index pointer into accumulator; FA uses immediate byte.
// - F6 shifts accumulator right, old LSB into carry, zero into MSB.
// - 76 rotates right through carry: LSB to carry, old carry to MSB.
// - FE shifts accumulator left, old MSB into carry, zero into LSB.
// - 7E rotates left through carry: MSB to carry, old carry to LSB.
// - F4 memory and FC immediate add to accumulator, carry-out to carry flag.
// - 74 memory and 7C immediate add operand plus carry, carry-out kept.
// - F7 memory and FF immediate subtract from accumulator; carry zero means borrow.
// - 77 subtracts memory plus inverted carry from accumulator, carry stored.
// - Each instruction takes two machine cycles of eight clocks each.
`timescale 1ns/10ps
module bce_datapath (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Instruction hand-in from the sequencer
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [3:0] index_sel,
  input wire logic [3:0] pc_sel,
  output logic busy,
  output logic done,
  // External byte memory
  output logic [15:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  // Visible datapath state
  output logic [7:0] acc,
  output logic carry_flag
);

  // Decoded operation class
  typedef struct packed {
    logic uses_mem;     // reads memory operand
    logic is_store;     // writes accumulator to memory
    logic ptr_inc;      // pointer +1 after the access
    logic ptr_dec;      // pointer -1 after the access
    logic [1:0] sel;    // 0 nibble, 1 index, 2 program counter
    logic legal;        // opcode belongs to this datapath
  } bce_dec_t;

  // All control state in one record
  typedef struct packed {
    bce_pkg::bce_state_t state;
    logic [3:0] tick;
    logic [7:0] op;
    logic [3:0] xs;
    logic [3:0] ps;
    logic [7:0] opnd;
    logic [7:0] acc;
    logic carry;
    logic done;
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } bce_state_rec_t;

  // Pointer array lives apart from the record: it is a memory, not control
  logic [15:0] ptr_ff [16];
  bce_state_rec_t cur_ff;
  bce_state_rec_t nxt_cur;
  logic ptr_we;
  logic [3:0] ptr_widx;
  logic [15:0] ptr_wval;

  // Decode of the held opcode
  function automatic bce_dec_t decode(input logic [7:0] op);
    bce_dec_t d;
    d = '0;
    case (op[7:4])
      bce_pkg::OPH_LOAD_N: begin
        d.legal = (op[3:0] != 4'h0);
        d.uses_mem = d.legal;
      end
      bce_pkg::OPH_INC_N, bce_pkg::OPH_DEC_N,
      bce_pkg::OPH_GET_LO, bce_pkg::OPH_GET_HI,
      bce_pkg::OPH_PUT_LO, bce_pkg::OPH_PUT_HI: begin
        d.legal = 1'b1;
      end
      bce_pkg::OPH_LOAD_ADV: begin
        d.legal = 1'b1;
        d.uses_mem = 1'b1;
        d.ptr_inc = 1'b1;
      end
      bce_pkg::OPH_STORE_N: begin
        d.legal = 1'b1;
        d.is_store = 1'b1;
      end
      default: begin
        d.legal = 1'b1;
        d.sel = 2'h1;
        case (op)
          bce_pkg::OP_BUMP_X, bce_pkg::OP_ROR_C, bce_pkg::OP_ROL_C,
          bce_pkg::OP_SHR, bce_pkg::OP_SHL: begin
          end
          bce_pkg::OP_LDX_ADV: begin
            d.uses_mem = 1'b1;
            d.ptr_inc = 1'b1;
          end
          bce_pkg::OP_STX_BACK: begin
            d.is_store = 1'b1;
            d.ptr_dec = 1'b1;
          end
          bce_pkg::OP_LDX, bce_pkg::OP_OR_M, bce_pkg::OP_AND_M, bce_pkg::OP_XOR_M,
          bce_pkg::OP_ADD_M, bce_pkg::OP_SUB_M, bce_pkg::OP_ADD_C_M,
          bce_pkg::OP_SUB_B_M: begin
            d.uses_mem = 1'b1;
          end
          bce_pkg::OP_LD_I, bce_pkg::OP_OR_I, bce_pkg::OP_AND_I, bce_pkg::OP_XOR_I,
          bce_pkg::OP_ADD_I, bce_pkg::OP_SUB_I, bce_pkg::OP_ADD_C_I: begin
            d.uses_mem = 1'b1;
            d.ptr_inc = 1'b1;
            d.sel = 2'h2;
          end
          default: begin
            d.legal = 1'b0;
          end
        endcase
      end
    endcase
    return d;
  endfunction : decode

  bce_dec_t dec;
  logic [3:0] sel_idx;
  logic [15:0] sel_ptr;
  logic [8:0] alu_sum;
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_wr;

  // Selector mux: nibble, index or program counter picks the pointer
  always_comb begin
    dec = decode(cur_ff.op);
    case (dec.sel)
      2'h1: sel_idx = cur_ff.xs;
      2'h2: sel_idx = cur_ff.ps;
      default: sel_idx = cur_ff.op[3:0];
    endcase
    sel_ptr = ptr_ff[sel_idx];
  end

  // Accumulator and carry results; carry bit 8 of a 9-bit sum is bit 0-counted
  always_comb begin
    alu_sum = 9'h000;
    alu_res = cur_ff.acc;
    alu_c = cur_ff.carry;
    alu_wr = 1'b1;
    case (cur_ff.op)
      bce_pkg::OP_OR_M, bce_pkg::OP_OR_I: alu_res = cur_ff.acc | cur_ff.opnd;
      bce_pkg::OP_XOR_M, bce_pkg::OP_XOR_I: alu_res = cur_ff.acc ^ cur_ff.opnd;
      bce_pkg::OP_AND_M, bce_pkg::OP_AND_I: alu_res = cur_ff.acc & cur_ff.opnd;
      bce_pkg::OP_SHR: begin
        alu_res = {1'b0, cur_ff.acc[7:1]};
        alu_c = cur_ff.acc[0];
      end
      bce_pkg::OP_ROR_C: begin
        alu_res = {cur_ff.carry, cur_ff.acc[7:1]};
        alu_c = cur_ff.acc[0];
      end
      bce_pkg::OP_SHL: begin
        alu_res = {cur_ff.acc[6:0], 1'b0};
        alu_c = cur_ff.acc[7];
      end
      bce_pkg::OP_ROL_C: begin
        alu_res = {cur_ff.acc[6:0], cur_ff.carry};
        alu_c = cur_ff.acc[7];
      end
      bce_pkg::OP_ADD_M, bce_pkg::OP_ADD_I: begin
        alu_sum = {1'b0, cur_ff.acc} + {1'b0, cur_ff.opnd};
        alu_res = alu_sum[7:0];
        alu_c = alu_sum[8];
      end
      bce_pkg::OP_ADD_C_M, bce_pkg::OP_ADD_C_I: begin
        alu_sum = {1'b0, cur_ff.acc} + {1'b0, cur_ff.opnd} + {8'h00, cur_ff.carry};
        alu_res = alu_sum[7:0];
        alu_c = alu_sum[8];
      end
      bce_pkg::OP_SUB_M, bce_pkg::OP_SUB_I: begin
        // Two's complement: carry out set means no borrow
        alu_sum = {1'b0, cur_ff.acc} + {1'b0, ~cur_ff.opnd} + 9'h001;
        alu_res = alu_sum[7:0];
        alu_c = alu_sum[8];
      end
      bce_pkg::OP_SUB_B_M: begin
        alu_sum = {1'b0, cur_ff.acc} + {1'b0, ~cur_ff.opnd} + {8'h00, cur_ff.carry};
        alu_res = alu_sum[7:0];
        alu_c = alu_sum[8];
      end
      bce_pkg::OP_LDX, bce_pkg::OP_LDX_ADV, bce_pkg::OP_LD_I: alu_res = cur_ff.opnd;
      default: begin
        case (cur_ff.op[7:4])
          bce_pkg::OPH_LOAD_N, bce_pkg::OPH_LOAD_ADV: alu_res = cur_ff.opnd;
          bce_pkg::OPH_GET_LO: alu_res = sel_ptr[7:0];
          bce_pkg::OPH_GET_HI: alu_res = sel_ptr[15:8];
          default: alu_wr = 1'b0; // accumulator kept
        endcase
      end
    endcase
  end

  // Sequencer: idle, fetch to tick 12 (memory at MEM_TICK, second machine cycle), execute ticks 13 to 15
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.done = 1'b0;
    nxt_cur.rd = 1'b0;
    nxt_cur.wr = 1'b0;
    ptr_we = 1'b0;
    ptr_widx = sel_idx;
    ptr_wval = sel_ptr;
    case (cur_ff.state)
      bce_pkg::ST_IDLE: begin
        if (start) begin
          nxt_cur.op = opcode;
          nxt_cur.xs = index_sel;
          nxt_cur.ps = pc_sel;
          nxt_cur.tick = 4'h0;
          nxt_cur.state = bce_pkg::ST_FETCH;
        end
      end
      bce_pkg::ST_FETCH: begin
        nxt_cur.tick = cur_ff.tick + 4'h1;
        // Address settles early in the cycle; strobe one clock before capture
        nxt_cur.addr = sel_ptr;
        nxt_cur.wdata = cur_ff.acc;
        if (cur_ff.tick == bce_pkg::MEM_TICK - 4'h1) begin
          nxt_cur.rd = dec.uses_mem;
          nxt_cur.wr = dec.is_store;
        end
        if (cur_ff.tick == bce_pkg::MEM_TICK && dec.uses_mem) begin
          nxt_cur.opnd = mem_rdata;
        end
        if (cur_ff.tick == bce_pkg::MEM_TICK + 4'h1) begin
          nxt_cur.state = bce_pkg::ST_EXEC;
        end
      end
      bce_pkg::ST_EXEC: begin
        nxt_cur.tick = cur_ff.tick + 4'h1;
        if (cur_ff.tick == bce_pkg::LAST_TICK) begin
          nxt_cur.state = bce_pkg::ST_IDLE;
          nxt_cur.done = 1'b1;
          if (dec.legal) begin
            if (alu_wr) begin
              nxt_cur.acc = alu_res;
            end
            nxt_cur.carry = alu_c;
            ptr_we = 1'b1;
            // 16-bit arithmetic wraps modulo 65536 by width
            if (dec.ptr_inc || cur_ff.op[7:4] == bce_pkg::OPH_INC_N ||
                cur_ff.op == bce_pkg::OP_BUMP_X) begin
              ptr_wval = sel_ptr + 16'h0001;
            end else if (dec.ptr_dec || cur_ff.op[7:4] == bce_pkg::OPH_DEC_N) begin
              ptr_wval = sel_ptr - 16'h0001;
            end else if (cur_ff.op[7:4] == bce_pkg::OPH_PUT_LO) begin
              ptr_wval = {sel_ptr[15:8], cur_ff.acc};
            end else if (cur_ff.op[7:4] == bce_pkg::OPH_PUT_HI) begin
              ptr_wval = {cur_ff.acc, sel_ptr[7:0]};
            end else begin
              ptr_we = 1'b0;
            end
          end
        end
      end
      default: begin
        nxt_cur.state = bce_pkg::ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cur_ff <= '0;
      cur_ff.state <= bce_pkg::ST_IDLE;
      cur_ff.acc <= bce_pkg::ACC_RST;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // Pointer array, one generate slot per register
  for (genvar gi = 0; gi <= 15; gi++) begin : g_ptr
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        ptr_ff[gi] <= bce_pkg::PTR_RST;
      end else if (ptr_we && ptr_widx == 4'(gi)) begin
        ptr_ff[gi] <= ptr_wval;
      end
    end
  end

  // Outputs, all from flip-flops except busy, decoded from the state
  assign busy = (cur_ff.state != bce_pkg::ST_IDLE);
  assign done = cur_ff.done;
  assign mem_addr = cur_ff.addr;
  assign mem_rd = cur_ff.rd;
  assign mem_wr = cur_ff.wr;
  assign mem_wdata = cur_ff.wdata;
  assign acc = cur_ff.acc;
  assign carry_flag = cur_ff.carry;

endmodule : bce_datapath

// ==== dv/bce_chk.sv ====
/*
  Checker for the datapath handshake, memory strobes and shift results.
  Sees only the datapath ports; bound to every datapath instance below.
*/
`timescale 1ns/10ps
module bce_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Hand-in and status
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic busy,
  input wire logic done,
  // Memory side and state
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] acc,
  input wire logic carry_flag
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Accepted hand-in and the sixteen busy cycles after it; done is seen one cycle later
  sequence take_s; start && !busy; endsequence
  sequence busy_run_s; busy [*8] ##1 busy [*8] ##1 !busy; endsequence
  busy_span_a: assert property (take_s |=> busy_run_s)
    else $error("busy span wrong");
  done_time_a: assert property (take_s |-> ##17 done)
    else $error("done late or early");
  done_pulse_a: assert property (done |=> !done)
    else $error("done longer than one cycle");
  strobe_excl_a: assert property (!(mem_rd && mem_wr))
    else $error("read and write together");
  strobe_slot_a: assert property ((mem_rd || mem_wr) |-> ##5 done)
    else $error("strobe in wrong slot");
  addr_hold_a: assert property ((mem_rd || mem_wr) |=> ($stable(mem_addr) && $stable(mem_wdata)) [*4])
    else $error("address moved during access");
  store_data_a: assert property (mem_wr |-> mem_wdata == acc)
    else $error("store data not accumulator");
  state_hold_a: assert property (!done |-> $stable(acc) && $stable(carry_flag))
    else $error("state changed outside retire");
  // Shifts judged against the accumulator at hand-in
  // Hand-in condition spelled out: a named sequence cannot be an operand of &&
  shr_res_a: assert property (start && !busy && opcode == bce_pkg::OP_SHR |->
      ##17 {acc, carry_flag} == {1'b0, $past(acc, 17)})
    else $error("right shift wrong");
  shl_res_a: assert property (start && !busy && opcode == bce_pkg::OP_SHL |->
      ##17 {carry_flag, acc} == {$past(acc, 17), 1'b0})
    else $error("left shift wrong");
endmodule : bce_chk

bind bce_datapath bce_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .start(start),
  .opcode(opcode), .busy(busy), .done(done), .mem_addr(mem_addr), .mem_rd(mem_rd),
  .mem_wr(mem_wr), .mem_wdata(mem_wdata), .acc(acc), .carry_flag(carry_flag));

// ==== dv/bce_mem_model.sv ====
/*
  Byte-wide memory model facing the datapath.
  Assumes reads are sampled while the read strobe stands.
*/
`timescale 1ns/10ps
module bce_mem_model (
  // Clock
  input wire logic clk_sys,
  // Memory side
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem_q [logic [15:0]];
  logic [7:0] last_ff = 8'h00;
  // Unwritten bytes hold an address pattern so reads differ
  function automatic logic [7:0] peek(input logic [15:0] a);
    return mem_q.exists(a) ? mem_q[a] : (a[7:0] ^ a[15:8] ^ 8'h5A);
  endfunction : peek
  // Valid only under the strobe, else inverse of the last byte
  assign mem_rdata = mem_rd ? peek(mem_addr) : ~last_ff;
  // Write on the strobe edge
  always @(posedge clk_sys) begin
    if (mem_rd) last_ff <= mem_rdata;
    if (mem_wr) mem_q[mem_addr] = mem_wdata;
  end
endmodule : bce_mem_model

// ==== dv/tb.sv ====
/*
  Self-checking bench: random instruction stream against a reference model.
  Assumes the fixed 16-cycle answer and 17-cycle spacing of the hand-in.
*/
`timescale 1ns/10ps
module tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic [7:0] opcode = 8'h00;
  logic [3:0] index_sel = 4'h0;
  logic [3:0] pc_sel = 4'h0;
  logic busy, done, mem_rd, mem_wr, carry_flag;
  logic [15:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata, acc, m_acc, op;
  logic m_cy;
  logic [15:0] m_r [16];
  logic [7:0] m_mem [logic [15:0]];
  logic [8:0] eq [$];
  logic [24:0] aq [$];
  logic [8:0] e9;
  logic [24:0] e25;
  logic [31:0] seed = 32'h0000005D;
  logic [31:0] w;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [7:0] ex_tab [24] = '{8'h60, 8'h72, 8'h73, 8'h74, 8'h76, 8'h77, 8'h7C, 8'h7E,
    8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF6, 8'hF7, 8'hF8, 8'hF9, 8'hFA, 8'hFB, 8'hFC,
    8'hFE, 8'hFF, 8'hF5, 8'h00};
  logic [3:0] nb_tab [9] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA, 4'hB};

  bce_datapath dut (.clk_sys(clk_sys), .rst_n(rst_n), .start(start), .opcode(opcode),
    .index_sel(index_sel), .pc_sel(pc_sel), .busy(busy), .done(done), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .acc(acc), .carry_flag(carry_flag));
  bce_mem_model u_mem (.clk_sys(clk_sys), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  // 100 MHz clock
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [24:0] seen, input logic [24:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  // Reference execution; s holds carry above accumulator
  task automatic model(input logic [7:0] o, input logic [3:0] x, input logic [3:0] p);
    logic [3:0] n;
    logic [15:0] a;
    logic [7:0] m;
    logic [8:0] s;
    logic imm;
    logic nsel;
    logic wr;
    n = o[3:0];
    imm = o inside {8'hF8, 8'hF9, 8'hFA, 8'hFB, 8'hFC, 8'hFF, 8'h7C};
    nsel = o[7:4] inside {4'h0, 4'h4, 4'h5};
    wr = o[7:4] == 4'h5 || o == 8'h73;
    a = imm ? m_r[p] : (nsel ? m_r[n] : m_r[x]);
    m = m_mem.exists(a) ? m_mem[a] : (a[7:0] ^ a[15:8] ^ 8'h5A);
    s = {m_cy, m_acc};
    if (imm || (nsel && o != 8'h00) || o inside {8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF7,
        8'h72, 8'h73, 8'h74, 8'h77}) aq.push_back({wr, a, wr ? m_acc : 8'h00});
    casez (o)
      8'h00: s = s;
      8'h0?, 8'h4?, 8'hF0, 8'h72, 8'hF8: s[7:0] = m;
      8'h1?: m_r[n] = m_r[n] + 16'h0001;
      8'h2?: m_r[n] = m_r[n] - 16'h0001;
      8'h60: m_r[x] = m_r[x] + 16'h0001;
      8'h5?, 8'h73: m_mem[a] = m_acc;
      8'h8?: s[7:0] = m_r[n][7:0];
      8'h9?: s[7:0] = m_r[n][15:8];
      8'hA?: m_r[n][7:0] = m_acc;
      8'hB?: m_r[n][15:8] = m_acc;
      8'hF1, 8'hF9: s[7:0] = m_acc | m;
      8'hF2, 8'hFA: s[7:0] = m_acc & m;
      8'hF3, 8'hFB: s[7:0] = m_acc ^ m;
      8'hF6: s = {m_acc[0], 1'b0, m_acc[7:1]};
      8'h76: s = {m_acc[0], m_cy, m_acc[7:1]};
      8'hFE: s = {m_acc, 1'b0};
      8'h7E: s = {m_acc, m_cy};
      8'hF4, 8'hFC: s = {1'b0, m_acc} + {1'b0, m};
      8'h74, 8'h7C: s = {1'b0, m_acc} + {1'b0, m} + {8'h00, m_cy};
      8'hF7, 8'hFF: s = {1'b0, m_acc} + {1'b0, ~m} + 9'h001;
      8'h77: s = {1'b0, m_acc} + {1'b0, ~m} + {8'h00, m_cy};
      default: s = s;
    endcase
    if (o[7:4] == 4'h4) m_r[n] = m_r[n] + 16'h0001;
    if (o == 8'h72) m_r[x] = m_r[x] + 16'h0001;
    if (o == 8'h73) m_r[x] = m_r[x] - 16'h0001;
    if (imm) m_r[p] = m_r[p] + 16'h0001;
    m_cy = s[8];
    m_acc = s[7:0];
    eq.push_back(s);
  endtask : model

  // One instruction, with an optional stray start while busy
  task automatic issue(input logic [7:0] o, input logic [3:0] x, input logic [3:0] p,
      input logic poke);
    @(posedge clk_sys);
    start <= 1'b1;
    opcode <= o;
    index_sel <= x;
    pc_sel <= p;
    model(o, x, p);
    @(posedge clk_sys);
    start <= 1'b0;
    repeat (4) @(posedge clk_sys);
    start <= poke;
    opcode <= 8'h1F;
    @(posedge clk_sys);
    start <= 1'b0;
    repeat (10) @(posedge clk_sys);
  endtask : issue

  // Result watcher; each strobe and retire takes the oldest note
  always @(posedge clk_sys) begin
    if (done === 1'b1) begin
      e9 = eq.pop_front();
      chk(25'(acc), 25'(e9[7:0]));
      chk(25'(carry_flag), 25'(e9[8]));
    end
    if (mem_rd === 1'b1 || mem_wr === 1'b1) begin
      e25 = aq.pop_front();
      chk({mem_wr, mem_addr, mem_wr ? mem_wdata : 8'h00}, e25);
    end
  end

  // Hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      err_count++;
      end_sim();
    end
  end

  // Two runs, the second after a mid-run reset
  initial begin
    for (int k = 0; k < 2; k++) begin
      m_acc = 8'h00;
      m_cy = 1'b0;
      foreach (m_r[j]) m_r[j] = 16'h0000;
      rst_n <= 1'b0;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (int i = 0; i < 250; i++) begin
        w = xs();
        op = w[0] ? {nb_tab[w[4:1] % 9], w[11:8]} : ex_tab[w[16:12] % 24];
        if (w[0] && op == 8'h00) op = 8'h0F;
        issue(op, w[23:20], w[27:24], w[31]);
      end
      repeat (3) @(posedge clk_sys);
    end
    end_sim();
  end
endmodule : tb
